// file: rtl/cst_pkg.sv
// Constants and types for the core status and reset-cause block
package cst_pkg;
  localparam int PC_W = 13;
  localparam logic [12:0] RESTART_ADDR = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  // Bus map
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_CAUSE = 8'h04;
  localparam logic [7:0] ADR_CTRL = 8'h08;
  localparam logic [7:0] ADR_RESTART = 8'h0C;
  // Status fields
  localparam int ST_TO = 4;
  localparam int ST_PD = 3;
  localparam int ST_Z = 2;
  localparam int ST_DC = 1;
  localparam int ST_C = 0;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] STATUS_IMPL = 8'h1F;
  localparam logic [7:0] STATUS_WMASK = 8'h07;
  // Reset-cause fields
  localparam int RC_OVF = 7;
  localparam int RC_UNF = 6;
  localparam int RC_WDT = 4;
  localparam int RC_PIN = 3;
  localparam int RC_SOFT = 2;
  localparam int RC_POR = 1;
  localparam int RC_BOR = 0;
  localparam logic [7:0] CAUSE_RST = 8'h1D;
  localparam logic [7:0] CAUSE_IMPL = 8'hDF;
  // Control fields
  localparam int CTRL_STKEN = 0;
  localparam logic [7:0] CTRL_RST = 8'h01;
  // Restart-view fields
  localparam int RV_SLEEP = 16;
  localparam int RV_VPEND = 17;
  // Pin synchroniser reset levels: bit0 brown-out, bit1 reset pin (low active)
  localparam logic [1:0] PIN_RST = 2'b10;
  localparam int PIN_BOR = 0;
  localparam int PIN_EXT = 1;

  typedef enum logic [3:0]
  {
    OP_MOVE = 4'h0,
    OP_ADD = 4'h1,
    OP_SUB = 4'h2,
    OP_AND = 4'h3,
    OP_IOR = 4'h4,
    OP_XOR = 4'h5,
    OP_RRF = 4'h6,
    OP_RLF = 4'h7,
    OP_ZERO_REGISTER_OP = 4'h8
  } cst_op_e;
endpackage : cst_pkg

// file: rtl/cst_flag_alu.sv
// Result and flag computation for one core operation
`timescale 1ns/10ps
module cst_flag_alu
  import cst_pkg::*;
(
  input wire cst_op_e op_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic carry_i,
  output logic [7:0] result_o,
  output logic zero_o,
  output logic nibble_carry_o,
  output logic carry_o,
  output logic [2:0] affect_o
);
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] addend;
  logic add_cin;

  assign addend = (op_i == OP_SUB) ? ~b_i : b_i;
  assign add_cin = (op_i == OP_SUB);
  assign sum = {1'b0, a_i} + {1'b0, addend} + {8'h00, add_cin};
  assign low_sum = {1'b0, a_i[3:0]} + {1'b0, addend[3:0]} + {4'h0, add_cin};

  always_comb
  begin
    result_o = a_i;
    carry_o = carry_i;
    nibble_carry_o = 1'b0;
    affect_o = 3'b000;
    unique case (op_i)
      OP_ADD, OP_SUB:
      begin
        result_o = sum[7:0];
        carry_o = sum[8];
        nibble_carry_o = low_sum[4];
        affect_o = 3'b111;
      end
      OP_AND:
      begin
        result_o = a_i & b_i;
        affect_o = 3'b100;
      end
      OP_IOR:
      begin
        result_o = a_i | b_i;
        affect_o = 3'b100;
      end
      OP_XOR:
      begin
        result_o = a_i ^ b_i;
        affect_o = 3'b100;
      end
      OP_RRF:
      begin
        result_o = {carry_i, a_i[7:1]};
        carry_o = a_i[0];
        affect_o = 3'b001;
      end
      OP_RLF:
      begin
        result_o = {a_i[6:0], carry_i};
        carry_o = a_i[7];
        affect_o = 3'b001;
      end
      OP_ZERO_REGISTER_OP:
      begin
        result_o = 8'h00;
        affect_o = 3'b100;
      end
      OP_MOVE:
      begin
        result_o = a_i;
      end
      default:
      begin
        result_o = a_i;
      end
    endcase
  end

  assign zero_o = (result_o == 8'h00);
endmodule : cst_flag_alu

// file: rtl/cst_status_core.sv
// Status flags, reset-cause flags and restart control with Wishbone access
`timescale 1ns/10ps
module cst_status_core
  import cst_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core operation port
  input wire logic op_valid_i,
  input wire cst_op_e op_code_i,
  input wire logic [7:0] op_a_i,
  input wire logic [7:0] op_b_i,
  input wire logic op_dest_status_i,
  output logic [7:0] op_result_o,
  // Core events, same clock
  input wire logic instr_done_i,
  input wire logic [12:0] pc_i,
  input wire logic watchdog_clear_op_i,
  input wire logic sleep_op_i,
  input wire logic reset_op_i,
  input wire logic watchdog_timeout_i,
  input wire logic irq_wake_i,
  input wire logic global_irq_enable_i,
  input wire logic stack_over_i,
  input wire logic stack_under_i,
  // Asynchronous sources
  input wire logic brownout_i,
  input wire logic external_reset_pin_n_i,
  // Program counter control and state
  output logic restart_o,
  output logic [12:0] restart_addr_o,
  output logic push_return_o,
  output logic sleeping_o,
  output logic [7:0] status_o,
  output logic [7:0] reset_cause_o
);
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] cause_r;
  logic [7:0] cause_nxt;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic sleep_r;
  logic sleep_nxt;
  logic vpend_r;
  logic vpend_nxt;
  logic restart_r;
  logic restart_nxt;
  logic [12:0] raddr_r;
  logic [12:0] raddr_nxt;
  logic push_r;
  logic push_nxt;
  logic [7:0] result_r;
  logic ack_r;
  logic [31:0] rdat_r;

  // Pin synchronisers
  logic [1:0] pin_raw;
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic [1:0] pin_s3_r;
  logic [1:0] pin_lvl_r;
  logic [1:0] pin_chg;

  assign pin_raw = {external_reset_pin_n_i, brownout_i};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_pin
      always_ff @(posedge core_clk_i)
      begin
        if (rst_i)
        begin
          pin_s1_r[gi] <= PIN_RST[gi];
          pin_s2_r[gi] <= PIN_RST[gi];
          pin_s3_r[gi] <= PIN_RST[gi];
          pin_lvl_r[gi] <= PIN_RST[gi];
        end
        else
        begin
          pin_s1_r[gi] <= pin_raw[gi];
          pin_s2_r[gi] <= pin_s1_r[gi];
          pin_s3_r[gi] <= pin_s2_r[gi];
          if (pin_s2_r[gi] == pin_s3_r[gi])
          begin
            pin_lvl_r[gi] <= pin_s3_r[gi];
          end
        end
      end
      assign pin_chg[gi] = (pin_s2_r[gi] == pin_s3_r[gi]) &&
                           (pin_s3_r[gi] != pin_lvl_r[gi]);
    end
  endgenerate

  // Reset and wake source events
  wire bor_evt = pin_chg[PIN_BOR] & pin_s3_r[PIN_BOR];
  wire pin_evt = pin_chg[PIN_EXT] & ~pin_s3_r[PIN_EXT];
  wire wdt_evt = watchdog_timeout_i;
  wire stk_en = ctrl_r[CTRL_STKEN];
  wire ovf_evt = stack_over_i & stk_en;
  wire unf_evt = stack_under_i & stk_en;
  wire irq_evt = irq_wake_i & sleep_r;

  // Operation result and flags
  logic [7:0] alu_result;
  logic alu_zero;
  logic alu_dc;
  logic alu_c;
  logic [2:0] alu_affect;

  cst_flag_alu u_alu
  (
    .op_i(op_code_i),
    .a_i(op_a_i),
    .b_i(op_b_i),
    .carry_i(status_r[ST_C]),
    .result_o(alu_result),
    .zero_o(alu_zero),
    .nibble_carry_o(alu_dc),
    .carry_o(alu_c),
    .affect_o(alu_affect)
  );

  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire hit_status = (wb_adr_i == ADR_STATUS);
  wire hit_cause = (wb_adr_i == ADR_CAUSE);
  wire hit_ctrl = (wb_adr_i == ADR_CTRL);
  wire hit_restart = (wb_adr_i == ADR_RESTART);
  wire [7:0] wbyte = wb_dat_i[7:0];
  wire op_flags = op_valid_i & (alu_affect != 3'b000);
  wire op_to_status = op_valid_i & op_dest_status_i;
  wire [7:0] flag_vec = {5'b00000, alu_zero, alu_dc, alu_c};
  wire [7:0] aff_vec = {5'b00000, alu_affect};
  wire [31:0] restart_view = {14'h0000, vpend_r, sleep_r, 3'b000, raddr_r};
  wire [31:0] rdat_nxt = hit_status ? {24'h000000, status_r} :
                         hit_cause ? {24'h000000, cause_r} :
                         hit_ctrl ? {24'h000000, ctrl_r} :
                         hit_restart ? restart_view : 32'h00000000;

  always_comb
  begin
    status_nxt = status_r;
    cause_nxt = cause_r;
    ctrl_nxt = ctrl_r;
    sleep_nxt = sleep_r;
    vpend_nxt = vpend_r;
    restart_nxt = 1'b0;
    raddr_nxt = raddr_r;
    push_nxt = 1'b0;
    // Software writes: only low flags of status are writable
    if (bus_wr && hit_status)
    begin
      status_nxt = (status_r & ~STATUS_WMASK) | (wbyte & STATUS_WMASK);
    end
    if (bus_wr && hit_cause)
    begin
      cause_nxt = wbyte & CAUSE_IMPL;
    end
    if (bus_wr && hit_ctrl)
    begin
      ctrl_nxt = {7'h00, wbyte[CTRL_STKEN]};
    end
    // Core write with status as destination
    if (op_to_status)
    begin
      if (op_flags)
      begin
        // Affected low flags take hardware values; all other bits keep their value, result dropped
        status_nxt = (status_r & ~STATUS_WMASK) |
                     (status_r & STATUS_WMASK & ~aff_vec);
      end
      else
      begin
        status_nxt = (status_r & ~STATUS_WMASK) |
                     (alu_result & STATUS_WMASK);
      end
    end
    if (op_flags)
    begin
      status_nxt = (status_nxt & ~aff_vec) | (flag_vec & aff_vec);
    end
    // Watchdog clear and sleep entry
    if (watchdog_clear_op_i)
    begin
      status_nxt[ST_TO] = 1'b1;
      status_nxt[ST_PD] = 1'b1;
    end
    else if (sleep_op_i)
    begin
      status_nxt[ST_TO] = 1'b1;
      status_nxt[ST_PD] = 1'b0;
      sleep_nxt = 1'b1;
    end
    // Vector entry after the instruction following an interrupt wake
    if (vpend_r && instr_done_i)
    begin
      vpend_nxt = 1'b0;
      restart_nxt = 1'b1;
      raddr_nxt = IRQ_VECTOR;
      push_nxt = 1'b1;
    end
    // Reset and wake sources, highest priority first, applied after all other updates
    if (bor_evt)
    begin
      cause_nxt[RC_OVF] = 1'b0;
      cause_nxt[RC_UNF] = 1'b0;
      cause_nxt[RC_PIN] = 1'b1;
      cause_nxt[RC_SOFT] = 1'b1;
      cause_nxt[RC_BOR] = 1'b0;
      status_nxt[ST_TO] = 1'b1;
      status_nxt[ST_PD] = 1'b1;
      sleep_nxt = 1'b0;
      vpend_nxt = 1'b0;
      push_nxt = 1'b0;
      restart_nxt = 1'b1;
      raddr_nxt = RESTART_ADDR;
    end
    else if (pin_evt)
    begin
      cause_nxt[RC_PIN] = 1'b0;
      if (sleep_r)
      begin
        status_nxt[ST_TO] = 1'b1;
        status_nxt[ST_PD] = 1'b0;
      end
      sleep_nxt = 1'b0;
      vpend_nxt = 1'b0;
      push_nxt = 1'b0;
      restart_nxt = 1'b1;
      raddr_nxt = RESTART_ADDR;
    end
    else if (wdt_evt && sleep_r)
    begin
      status_nxt[ST_TO] = 1'b0;
      status_nxt[ST_PD] = 1'b0;
      sleep_nxt = 1'b0;
      restart_nxt = 1'b1;
      raddr_nxt = pc_i + 13'h0001;
    end
    else if (wdt_evt)
    begin
      cause_nxt[RC_WDT] = 1'b0;
      status_nxt[ST_TO] = 1'b0;
      vpend_nxt = 1'b0;
      push_nxt = 1'b0;
      restart_nxt = 1'b1;
      raddr_nxt = RESTART_ADDR;
    end
    else if (ovf_evt || unf_evt)
    begin
      if (ovf_evt)
      begin
        cause_nxt[RC_OVF] = 1'b1;
      end
      if (unf_evt)
      begin
        cause_nxt[RC_UNF] = 1'b1;
      end
      sleep_nxt = 1'b0;
      vpend_nxt = 1'b0;
      push_nxt = 1'b0;
      restart_nxt = 1'b1;
      raddr_nxt = RESTART_ADDR;
    end
    else if (reset_op_i)
    begin
      cause_nxt[RC_SOFT] = 1'b0;
      sleep_nxt = 1'b0;
      vpend_nxt = 1'b0;
      push_nxt = 1'b0;
      restart_nxt = 1'b1;
      raddr_nxt = RESTART_ADDR;
    end
    else if (irq_evt)
    begin
      status_nxt[ST_TO] = 1'b1;
      status_nxt[ST_PD] = 1'b0;
      sleep_nxt = 1'b0;
      vpend_nxt = global_irq_enable_i;
      restart_nxt = 1'b1;
      raddr_nxt = pc_i + 13'h0001;
    end
    status_nxt = status_nxt & STATUS_IMPL;
  end

  // Flag and restart state
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      status_r <= STATUS_RST;
      cause_r <= CAUSE_RST;
      ctrl_r <= CTRL_RST;
      sleep_r <= 1'b0;
      vpend_r <= 1'b0;
      restart_r <= 1'b0;
      raddr_r <= RESTART_ADDR;
      push_r <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      cause_r <= cause_nxt;
      ctrl_r <= ctrl_nxt;
      sleep_r <= sleep_nxt;
      vpend_r <= vpend_nxt;
      restart_r <= restart_nxt;
      raddr_r <= raddr_nxt;
      push_r <= push_nxt;
    end
  end

  // Operation result register
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      result_r <= 8'h00;
    end
    else if (op_valid_i)
    begin
      result_r <= alu_result;
    end
  end

  // Bus answer: one wait state, ack one cycle
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      rdat_r <= 32'h00000000;
    end
    else
    begin
      ack_r <= bus_req;
      if (bus_req)
      begin
        rdat_r <= rdat_nxt;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign op_result_o = result_r;
  assign restart_o = restart_r;
  assign restart_addr_o = raddr_r;
  assign push_return_o = push_r;
  assign sleeping_o = sleep_r;
  assign status_o = status_r;
  assign reset_cause_o = cause_r;
endmodule : cst_status_core

// file: tb/cst_status_core_sva.sv
// Checker on the ports of the status and reset-cause block
`timescale 1ns/10ps
module cst_status_core_sva
  import cst_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire logic [12:0] pc_i,
  input wire logic watchdog_clear_op_i,
  input wire logic sleep_op_i,
  input wire logic reset_op_i,
  input wire logic watchdog_timeout_i,
  input wire logic irq_wake_i,
  input wire logic stack_over_i,
  input wire logic stack_under_i,
  input wire logic restart_o,
  input wire logic [12:0] restart_addr_o,
  input wire logic push_return_o,
  input wire logic sleeping_o,
  input wire logic [7:0] status_o,
  input wire logic [7:0] reset_cause_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  // No core reset source that outranks the flag events
  wire quiet = !(reset_op_i | watchdog_timeout_i | stack_over_i |
    stack_under_i);
  wire idle = quiet && !(sleep_op_i | watchdog_clear_op_i | irq_wake_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_restart0;
    restart_o && restart_addr_o == RESTART_ADDR;
  endsequence
  sequence s_wake;
    restart_o && restart_addr_o == $past(pc_i) + 13'h1;
  endsequence
  property p_ack;
    s_take |=> wb_ack_o;
  endproperty
  property p_top;
    status_o[7:5] == 3'b000;
  endproperty
  property p_st_wr;
    s_take ##0 (wb_we_i && wb_adr_i == ADR_STATUS && idle) |=>
      $stable(status_o[4:3]);
  endproperty
  property p_sleep;
    sleep_op_i && !watchdog_clear_op_i && quiet |=> status_o[4:3] == 2'b10;
  endproperty
  property p_clear;
    watchdog_clear_op_i && !sleep_op_i && quiet |=> status_o[4:3] == 2'b11;
  endproperty
  property p_soft;
    reset_op_i && quiet == 1'b0 && !watchdog_timeout_i && !stack_over_i &&
      !stack_under_i |=> s_restart0 ##0 !reset_cause_o[RC_SOFT];
  endproperty
  property p_wdt_rst;
    watchdog_timeout_i && !sleeping_o |=> s_restart0 ##0
      (!reset_cause_o[RC_WDT] && !status_o[ST_TO]);
  endproperty
  property p_wdt_wake;
    watchdog_timeout_i && sleeping_o |=> s_wake ##0
      (status_o[4:3] == 2'b00 && !sleeping_o);
  endproperty
  property p_irq;
    irq_wake_i && sleeping_o && quiet |=> s_wake ##0
      (status_o[4:3] == 2'b10 && !sleeping_o);
  endproperty
  property p_vec;
    push_return_o |-> restart_o && restart_addr_o == IRQ_VECTOR;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack late");
  a_top: assert property (p_top) else $error("status top bits set");
  a_st_wr: assert property (p_st_wr) else $error("flag written");
  a_sleep: assert property (p_sleep) else $error("sleep flags");
  a_clear: assert property (p_clear) else $error("clear flags");
  a_soft: assert property (p_soft) else $error("soft reset");
  a_wdt_rst: assert property (p_wdt_rst) else $error("wdt reset");
  a_wdt_wake: assert property (p_wdt_wake) else $error("wdt wake");
  a_irq: assert property (p_irq) else $error("irq wake");
  a_vec: assert property (p_vec) else $error("vector entry");
endmodule : cst_status_core_sva

bind cst_status_core cst_status_core_sva u_cst_status_core_sva (.*);

// file: tb/cst_status_core_test.sv
// Self-checking bench for the status and reset-cause block
`timescale 1ns/10ps
module cst_status_core_test;
  import cst_pkg::*;
  logic clk = 0, rst = 1, cyc = 0, we = 0, opv = 0, opv_d = 0, dst = 0;
  logic global_irq_enable = 1, bor = 0, pin_n = 1, stb = 0, ack, rs, push, slp_o;
  logic [3:0] sel = 0;
  logic [7:0] ev = 0, adr = 0, a = 0, b = 0, res, st, rc;
  logic [31:0] wdat = 0, rdat, seed = 13;
  logic [12:0] pc = 13'h0123, raddr;
  logic [2:0] fl = 0;
  cst_op_e opc = OP_MOVE;
  logic [31:0] rd_q[$];
  logic [15:0] op_q[$];
  logic [13:0] rs_q[$];
  int failures = 0, n_checks = 0, ticks = 0;

  cst_status_core u_cst_status_core (
    .core_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .op_valid_i(opv), .op_code_i(opc),
    .op_a_i(a), .op_b_i(b), .op_dest_status_i(dst), .op_result_o(res),
    .instr_done_i(ev[5]), .pc_i(pc), .watchdog_clear_op_i(ev[0]),
    .sleep_op_i(ev[1]), .reset_op_i(ev[2]), .watchdog_timeout_i(ev[3]),
    .irq_wake_i(ev[4]), .global_irq_enable_i(global_irq_enable), .stack_over_i(ev[6]),
    .stack_under_i(ev[7]), .brownout_i(bor),
    .external_reset_pin_n_i(pin_n), .restart_o(rs),
    .restart_addr_o(raddr), .push_return_o(push), .sleeping_o(slp_o),
    .status_o(st), .reset_cause_o(rc));

  always #5 clk = ~clk;

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic bus(input logic w, input logic [7:0] ad,
    input logic [31:0] d, input logic [3:0] s = 4'hF);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= ad;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
    @(posedge clk);
  endtask : bus

  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, ad, 32'h0);
  endtask : rd

  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev <= 8'h00;
    repeat (3) @(posedge clk);
  endtask : pulse

  task automatic op(input cst_op_e c, input logic [7:0] x, input logic [7:0] y,
    input logic d);
    logic sub;
    logic [7:0] y2;
    logic [7:0] r;
    logic [8:0] s;
    logic [4:0] n;
    sub = (c == OP_SUB);
    y2 = sub ? ~y : y;
    s = {1'b0, x} + {1'b0, y2} + 9'(sub);
    n = {1'b0, x[3:0]} + {1'b0, y2[3:0]} + 5'(sub);
    case (c)
      OP_MOVE: r = x;
      OP_AND: r = x & y;
      OP_IOR: r = x | y;
      OP_XOR: r = x ^ y;
      OP_RRF: r = {fl[0], x[7:1]};
      OP_RLF: r = {x[6:0], fl[0]};
      OP_ZERO_REGISTER_OP: r = 8'h00;
      default: r = s[7:0];
    endcase
    if (c == OP_MOVE)
      fl = d ? x[2:0] : fl;
    else if (c == OP_RRF || c == OP_RLF)
      fl[0] = (c == OP_RRF) ? x[0] : x[7];
    else
      fl[2] = (r == 8'h00);
    if (c == OP_ADD || sub)
      fl[1:0] = {n[4], s[8]};
    op_q.push_back({5'h00, fl, r});
    opc <= c;
    a <= x;
    b <= y;
    dst <= d;
    opv <= 1'b1;
    @(posedge clk);
  endtask : op

  always @(posedge clk)
  begin
    ticks++;
    opv_d <= opv;
    if (opv_d)
      chk({st[2:0], res}, op_q.pop_front());
    if (ack === 1'b1 && we === 1'b0)
      chk(rdat, rd_q.pop_front());
    if (rs === 1'b1)
      chk({push, raddr}, rs_q.size() ? rs_q.pop_front() : 14'h3FFF);
    if (ticks > 2000)
    begin
      failures++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ADR_STATUS, 32'h18);
    rd(ADR_CAUSE, 32'h1D);
    rd(8'h10, 32'h0);
    bus(1'b1, ADR_STATUS, 32'h0);
    rd(ADR_STATUS, 32'h18);
    bus(1'b1, ADR_STATUS, 32'hFF, 4'hE);
    rd(ADR_STATUS, 32'h18);
    bus(1'b1, ADR_STATUS, 32'hFF);
    rd(ADR_STATUS, 32'h1F);
    fl = 3'h7;
    $display("register test done");
    rs_q.push_back(14'h0);
    pulse(2);
    rd(ADR_CAUSE, 32'h19);
    rs_q.push_back(14'h0);
    pulse(3);
    rd(ADR_STATUS, 32'h0F);
    rd(ADR_CAUSE, 32'h09);
    pulse(0);
    rd(ADR_STATUS, 32'h1F);
    rs_q.push_back(14'h0);
    pulse(6);
    rs_q.push_back(14'h0);
    pulse(7);
    rd(ADR_CAUSE, 32'hC9);
    bus(1'b1, ADR_CTRL, 32'h0);
    pulse(6);
    rd(ADR_CAUSE, 32'hC9);
    pulse(1);
    rd(ADR_STATUS, 32'h17);
    rs_q.push_back({1'b0, pc + 13'h1});
    pulse(3);
    rd(ADR_STATUS, 32'h07);
    pulse(1);
    rs_q.push_back({1'b0, pc + 13'h1});
    rs_q.push_back({1'b1, IRQ_VECTOR});
    pulse(4);
    pulse(5);
    rd(ADR_STATUS, 32'h17);
    rs_q.push_back(14'h0);
    pin_n <= 1'b0;
    repeat (8) @(posedge clk);
    pin_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(ADR_CAUSE, 32'hC1);
    rs_q.push_back(14'h0);
    bor <= 1'b1;
    repeat (8) @(posedge clk);
    bor <= 1'b0;
    repeat (8) @(posedge clk);
    rd(ADR_STATUS, 32'h1F);
    rd(ADR_CAUSE, 32'h0C);
    chk({st, rc}, 16'h1F0C);
    pc <= 13'h1ABC;
    global_irq_enable <= 1'b0;
    pulse(1);
    chk(slp_o, 1'b1);
    rd(ADR_RESTART, 32'h00010000);
    rs_q.push_back({1'b0, 13'h1ABD});
    pulse(4);
    pulse(5);
    rd(ADR_RESTART, 32'h00001ABD);
    pulse(1);
    rs_q.push_back(14'h0);
    pin_n <= 1'b0;
    repeat (8) @(posedge clk);
    pin_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk({slp_o, st}, 9'h017);
    rd(ADR_CAUSE, 32'h04);
    $display("event test done");
    op(OP_MOVE, 8'hA5, 8'h00, 1'b1);
    op(OP_ADD, 8'h0F, 8'hF1, 1'b1);
    op(OP_SUB, 8'h10, 8'h11, 1'b0);
    for (int i = 0; i < 64; i++)
      op(cst_op_e'(4'(i % 8 + 1)), rnd(), rnd(), i[2]);
    opv <= 1'b0;
    repeat (3) @(posedge clk);
    $display("flag test done");
    chk(rd_q.size() + op_q.size() + rs_q.size(), 0);
    give_verdict();
  end
endmodule : cst_status_core_test
